// ===== hw/pemi_top.sv
// Purpose: staged burst memory port and register block of the parity engine
// Assumes: memory clock is sampled by pclk, far slower than pclk
// Notes: galois datapath lies outside; it streams words through the acc ports
`timescale 1ns/1ps
module pemi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pemi_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic mem_clk,
  output logic [31:0] mem_req_address,
  output logic mem_access_request,
  output logic mem_read_not_write,
  output logic [1:0] mem_burst_length_code,
  input wire logic mem_request_ack,
  output logic read_word_ack_rise,
  output logic write_word_ack_rise,
  input wire logic [4:0] read_word_index_rise,
  output logic read_burst_finished,
  output logic read_path_clear,
  input wire logic [31:0] read_bus_rise,
  input wire logic [31:0] read_bus_fall,
  input wire logic read_word_valid,
  input wire logic ctrl_read_queue_empty,
  output logic [31:0] write_bus_rise,
  output logic [31:0] write_bus_fall,
  output logic write_burst_finished,
  output logic write_path_clear,
  input wire logic ctrl_write_in_progress,
  input wire logic ctrl_write_queue_full_rise,
  input wire logic ctrl_write_queue_full_fall,
  output logic accel_start,
  output logic accel_done,
  output logic [1:0] register_pair_select,
  output logic [31:0] config_input_a,
  output logic [31:0] config_input_b,
  output logic [31:0] acc_rd_data,
  output logic acc_rd_valid,
  input wire logic [31:0] acc_wr_data,
  input wire logic acc_wr_valid,
  output logic acc_wr_ready,
  output logic [31:0] loss_code,
  output logic [31:0] data_block_pointer_1,
  output logic [31:0] data_block_pointer_2,
  output logic [31:0] data_block_pointer_3,
  output logic [31:0] data_block_pointer_4,
  output logic [31:0] parity_p_pointer,
  output logic [31:0] parity_q_pointer,
  output logic [31:0] mode_word,
  output logic regenerate_request,
  output logic [3:0] status_indicator
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pemi_pkg::pemi_state_t state;
    logic regen;
    logic [1:0] led;
    logic [4:0] size;
    logic done_seen;
    logic [pemi_pkg::NUM_CFG-1:0][31:0] cfg;
    logic [31:0] prdata;
    logic link_prev;
    logic start;
    logic done;
    logic [1:0] sel;
    logic use_b;
    logic [2:0] block;
    logic [1:0] burst;
    logic [3:0] pair;
    logic half;
    logic [31:0] addr;
    logic req;
    logic rnw;
    logic [31:0] wr_rise;
    logic [31:0] wr_fall;
    logic [31:0] hold;
    logic [31:0] rd_data;
    logic rd_valid;
    logic rd_fin;
    logic wr_fin;
    logic clr_rd;
    logic clr_wr;
  } pemi_regs_t;

  pemi_regs_t r;
  pemi_regs_t next_r;
  logic [pemi_pkg::SYNC_W-1:0] sy;
  logic [9:0] idx;
  logic mapped;
  logic in_cfg;
  logic [2:0] slot;
  logic wr_en;
  logic abort_req;
  logic link_edge;
  logic busy;
  logic [31:0] rd_word;
  logic [2:0] total;
  logic [2:0] tgt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] pemi_writes(input logic [2:0] m);
    case (m)
      pemi_pkg::MODE_UPDATE_PQ: pemi_writes = 3'h3;
      pemi_pkg::MODE_DOUBLE_DD, pemi_pkg::MODE_DOUBLE_DQ, pemi_pkg::MODE_DOUBLE_DP: pemi_writes = 3'h2;
      default: pemi_writes = 3'h1;
    endcase
  endfunction : pemi_writes

  // returns {pair select, take second bus}
  function automatic logic [2:0] pemi_target(input logic [2:0] blk, input logic [2:0] m);
    case (blk)
      3'h0: pemi_target = {pemi_pkg::PAIR_D1_D2, 1'b0};
      3'h1: pemi_target = {pemi_pkg::PAIR_D1_D2, 1'b1};
      3'h2: pemi_target = {pemi_pkg::PAIR_D3_D4, 1'b0};
      3'h3: pemi_target = {pemi_pkg::PAIR_P_Q, (m == pemi_pkg::MODE_SINGLE_Q)};
      3'h4: pemi_target = {pemi_pkg::PAIR_P_Q, 1'b1};
      default: pemi_target = {pemi_pkg::PAIR_D1_D2, 1'b0};
    endcase
  endfunction : pemi_target

  // ----------------------------------------------------------------
  // input capture and config pair select
  // ----------------------------------------------------------------
  // data words ride the same two stages as the link clock, so they line up with its edge
  pemi_sync #(.W(pemi_pkg::SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({read_bus_fall, read_bus_rise, ctrl_write_in_progress, ctrl_write_queue_full_fall,
        ctrl_write_queue_full_rise, ctrl_read_queue_empty, read_word_valid, mem_request_ack, mem_clk}),
    .q(sy)
  );

  pemi_cfg_if cfg_bus();
  assign cfg_bus.sel = r.sel;

  pemi_cfg_mux u_cfg_mux (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(r.cfg),
    .bus(cfg_bus)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.done = 1'b0;
    next_r.rd_valid = 1'b0;
    link_edge = sy[pemi_pkg::SB_CLK] & ~r.link_prev;
    next_r.link_prev = sy[pemi_pkg::SB_CLK];
    busy = (r.state != pemi_pkg::S_IDLE);
    total = pemi_pkg::READ_BLOCKS + pemi_writes(r.cfg[pemi_pkg::SLOT_MODE][pemi_pkg::MODE_HI:pemi_pkg::MODE_LO]);
    tgt = pemi_target(r.block, r.cfg[pemi_pkg::SLOT_MODE][pemi_pkg::MODE_HI:pemi_pkg::MODE_LO]);
    idx = paddr[pemi_pkg::ADDR_W-1:2];
    mapped = (paddr[1:0] == 2'h0) && (idx >= pemi_pkg::IDX_REGEN) && (idx <= pemi_pkg::IDX_CTRL);
    in_cfg = (idx >= pemi_pkg::IDX_LOSS) && (idx <= pemi_pkg::IDX_MODE);
    slot = 3'(idx - pemi_pkg::IDX_LOSS);
    wr_en = psel & penable & pwrite & mapped;
    abort_req = wr_en && (idx == pemi_pkg::IDX_CTRL) && (pwdata[1:0] != 2'h0);
    // read data is latched in the setup phase so prdata comes from a flop
    case (idx)
      pemi_pkg::IDX_REGEN: rd_word = {31'h0, r.regen};
      pemi_pkg::IDX_LED: rd_word = {28'h0, r.led, r.done_seen, busy};
      pemi_pkg::IDX_SIZE: rd_word = {27'h0, r.size};
      pemi_pkg::IDX_CTRL: rd_word = {24'h0, r.state, 3'h0, busy};
      default: rd_word = (in_cfg && mapped) ? r.cfg[slot] : 32'h0;
    endcase
    if (psel && !penable) begin
      next_r.prdata = mapped ? rd_word : 32'h0;
    end
    if (wr_en && in_cfg) begin
      next_r.cfg[slot] = pwdata;
    end
    if (wr_en && (idx == pemi_pkg::IDX_LED)) begin
      next_r.led = pwdata[3:2];
    end
    if (wr_en && (idx == pemi_pkg::IDX_SIZE)) begin
      next_r.size = pwdata[4:0];
    end

    case (r.state)
      pemi_pkg::S_IDLE: begin
        if (r.regen) begin
          next_r.start = 1'b1;
          next_r.done_seen = 1'b0;
          next_r.block = 3'h0;
          next_r.state = pemi_pkg::S_SETUP;
        end
      end
      pemi_pkg::S_SETUP: begin
        if (r.block == total) begin
          next_r.state = pemi_pkg::S_DONE;
        end else begin
          next_r.sel = tgt[2:1];
          next_r.use_b = tgt[0];
          next_r.rnw = (r.block < pemi_pkg::READ_BLOCKS);
          next_r.half = 1'b0;
          next_r.state = pemi_pkg::S_FETCH;
        end
      end
      pemi_pkg::S_FETCH: begin
        // second cycle: the registered pair has caught up with the select
        if (!r.half) begin
          next_r.half = 1'b1;
        end else begin
          next_r.half = 1'b0;
          next_r.addr = r.use_b ? cfg_bus.cfg_b : cfg_bus.cfg_a;
          next_r.burst = 2'h0;
          next_r.req = 1'b1;
          next_r.state = pemi_pkg::S_REQ;
        end
      end
      pemi_pkg::S_REQ: begin
        // request, address and direction frozen until the acknowledge is seen
        if (link_edge && sy[pemi_pkg::SB_ACK]) begin
          next_r.req = 1'b0;
          next_r.pair = 4'h0;
          next_r.half = 1'b0;
          next_r.state = r.rnw ? pemi_pkg::S_RD : pemi_pkg::S_WR_FILL;
        end
      end
      pemi_pkg::S_RD: begin
        if (r.half) begin
          next_r.rd_data = r.hold;
          next_r.rd_valid = 1'b1;
          next_r.half = 1'b0;
          if (r.pair == pemi_pkg::LAST_PAIR) begin
            next_r.rd_fin = 1'b1;
            next_r.state = pemi_pkg::S_RD_FIN;
          end else begin
            next_r.pair = r.pair + 4'h1;
          end
        end else if (link_edge && sy[pemi_pkg::SB_RVALID] && !sy[pemi_pkg::SB_REMPTY]) begin
          next_r.rd_data = sy[pemi_pkg::SB_RISE_LO +: 32];
          next_r.hold = sy[pemi_pkg::SB_FALL_LO +: 32];
          next_r.rd_valid = 1'b1;
          next_r.half = 1'b1;
        end
      end
      pemi_pkg::S_RD_FIN: begin
        if (link_edge) begin
          next_r.rd_fin = 1'b0;
          next_r.state = pemi_pkg::S_NEXT;
        end
      end
      pemi_pkg::S_WR_FILL: begin
        if (acc_wr_valid) begin
          if (!r.half) begin
            next_r.wr_rise = acc_wr_data;
            next_r.half = 1'b1;
          end else begin
            next_r.wr_fall = acc_wr_data;
            next_r.half = 1'b0;
            next_r.state = pemi_pkg::S_WR_PUSH;
          end
        end
      end
      pemi_pkg::S_WR_PUSH: begin
        if (link_edge && !sy[pemi_pkg::SB_FULL_R] && !sy[pemi_pkg::SB_FULL_F]) begin
          if (r.pair == pemi_pkg::LAST_PAIR) begin
            next_r.wr_fin = 1'b1;
            next_r.state = pemi_pkg::S_WR_FIN;
          end else begin
            next_r.pair = r.pair + 4'h1;
            next_r.state = pemi_pkg::S_WR_FILL;
          end
        end
      end
      pemi_pkg::S_WR_FIN: begin
        if (link_edge) begin
          next_r.wr_fin = 1'b0;
          next_r.state = pemi_pkg::S_WR_SETTLE;
        end
      end
      pemi_pkg::S_WR_SETTLE: begin
        if (link_edge && !sy[pemi_pkg::SB_WBUSY]) begin
          next_r.state = pemi_pkg::S_NEXT;
        end
      end
      pemi_pkg::S_NEXT: begin
        // other ports may be served between these staged requests
        if (r.burst == pemi_pkg::LAST_BURST) begin
          next_r.block = r.block + 3'h1;
          next_r.state = pemi_pkg::S_SETUP;
        end else begin
          next_r.burst = r.burst + 2'h1;
          next_r.addr = r.addr + pemi_pkg::BURST_BYTES;
          next_r.req = 1'b1;
          next_r.state = pemi_pkg::S_REQ;
        end
      end
      pemi_pkg::S_DONE: begin
        next_r.done = 1'b1;
        next_r.done_seen = 1'b1;
        next_r.state = pemi_pkg::S_IDLE;
      end
      pemi_pkg::S_ABORT: begin
        if (link_edge) begin
          next_r.half = 1'b1; // leave on the second link edge so the clears span a whole link period
          next_r.clr_rd = r.clr_rd & ~r.half;
          next_r.clr_wr = r.clr_wr & ~r.half;
          next_r.state = r.half ? pemi_pkg::S_IDLE : pemi_pkg::S_ABORT;
        end
      end
      default: begin
        next_r.state = pemi_pkg::S_IDLE;
      end
    endcase

    // abort drops the request and holds the chosen clears for one link period
    if (abort_req) begin
      next_r.state = pemi_pkg::S_ABORT;
      next_r.req = 1'b0;
      next_r.rd_fin = 1'b0;
      next_r.wr_fin = 1'b0;
      next_r.half = 1'b0;
      next_r.clr_rd = pwdata[0];
      next_r.clr_wr = pwdata[1];
    end

    // completion clears the bit, but a software write in the same cycle wins
    if ((r.state == pemi_pkg::S_DONE) || abort_req) begin
      next_r.regen = 1'b0;
    end
    if (wr_en && (idx == pemi_pkg::IDX_REGEN)) begin
      next_r.regen = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = r.prdata;
  assign mem_req_address = r.addr;
  assign mem_access_request = r.req;
  assign mem_read_not_write = r.rnw;
  assign mem_burst_length_code = pemi_pkg::BURST_CODE_32;
  // burst only: word index inputs are left unread
  assign read_word_ack_rise = 1'b0;
  assign write_word_ack_rise = 1'b0;
  assign read_burst_finished = r.rd_fin;
  assign read_path_clear = r.clr_rd;
  assign write_bus_rise = r.wr_rise;
  assign write_bus_fall = r.wr_fall;
  assign write_burst_finished = r.wr_fin;
  assign write_path_clear = r.clr_wr;
  assign accel_start = r.start;
  assign accel_done = r.done;
  assign register_pair_select = r.sel;
  assign config_input_a = cfg_bus.cfg_a;
  assign config_input_b = cfg_bus.cfg_b;
  assign acc_rd_data = r.rd_data;
  assign acc_rd_valid = r.rd_valid;
  assign acc_wr_ready = (r.state == pemi_pkg::S_WR_FILL);
  assign loss_code = r.cfg[pemi_pkg::SLOT_LOSS];
  assign data_block_pointer_1 = r.cfg[pemi_pkg::SLOT_D1];
  assign data_block_pointer_2 = r.cfg[pemi_pkg::SLOT_D2];
  assign data_block_pointer_3 = r.cfg[pemi_pkg::SLOT_D3];
  assign data_block_pointer_4 = r.cfg[pemi_pkg::SLOT_D4];
  assign parity_p_pointer = r.cfg[pemi_pkg::SLOT_P];
  assign parity_q_pointer = r.cfg[pemi_pkg::SLOT_Q];
  assign mode_word = r.cfg[pemi_pkg::SLOT_MODE];
  assign regenerate_request = r.regen;
  assign status_indicator = {r.led, r.done_seen, busy};
endmodule : pemi_top

// ===== pkg/pemi_pkg.sv
// Purpose: shared constants and types for the parity engine memory port and register block
// Assumes: apb byte address is four times the register index
// Notes: block size is fixed at 512 bytes, four bursts of 128 bytes
package pemi_pkg;
  localparam int ADDR_W = 12;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_REGEN = 10'h180;
  localparam logic [9:0] IDX_LOSS = 10'h181;
  localparam logic [9:0] IDX_MODE = 10'h188;
  localparam logic [9:0] IDX_RSVD = 10'h189;
  localparam logic [9:0] IDX_LED = 10'h18A;
  localparam logic [9:0] IDX_SIZE = 10'h18B;
  localparam logic [9:0] IDX_CTRL = 10'h18C;
  // config slots follow the index order, loss first and mode last
  localparam int NUM_CFG = 8;
  localparam logic [2:0] SLOT_LOSS = 3'h0;
  localparam logic [2:0] SLOT_D1 = 3'h1;
  localparam logic [2:0] SLOT_D2 = 3'h2;
  localparam logic [2:0] SLOT_D3 = 3'h3;
  localparam logic [2:0] SLOT_D4 = 3'h4;
  localparam logic [2:0] SLOT_P = 3'h5;
  localparam logic [2:0] SLOT_Q = 3'h6;
  localparam logic [2:0] SLOT_MODE = 3'h7;
  localparam int MODE_HI = 31;
  localparam int MODE_LO = 29;
  localparam logic [31:0] RESET_CFG = 32'h0000_0000;
  localparam logic [4:0] RESET_SIZE = 5'h00;
  // ----------------------------------------------------------------
  // operation modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SINGLE_D = 3'h0;
  localparam logic [2:0] MODE_SINGLE_P = 3'h1;
  localparam logic [2:0] MODE_SINGLE_Q = 3'h2;
  localparam logic [2:0] MODE_UPDATE_PQ = 3'h3;
  localparam logic [2:0] MODE_DOUBLE_DD = 3'h4;
  localparam logic [2:0] MODE_DOUBLE_DQ = 3'h5;
  localparam logic [2:0] MODE_DOUBLE_DP = 3'h7;
  // ----------------------------------------------------------------
  // register pair select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PAIR_LOSS_MODE = 2'h0;
  localparam logic [1:0] PAIR_D1_D2 = 2'h1;
  localparam logic [1:0] PAIR_D3_D4 = 2'h2;
  localparam logic [1:0] PAIR_P_Q = 2'h3;
  // ----------------------------------------------------------------
  // memory port
  // ----------------------------------------------------------------
  localparam logic [1:0] BURST_CODE_32 = 2'h3;
  localparam logic [31:0] BURST_BYTES = 32'h0000_0080;
  localparam logic [1:0] LAST_BURST = 2'h3;
  localparam logic [3:0] LAST_PAIR = 4'hF;
  localparam logic [2:0] READ_BLOCKS = 3'h3;
  // synchroniser bit positions
  localparam int SYNC_W = 71;
  localparam int SB_CLK = 0;
  localparam int SB_ACK = 1;
  localparam int SB_RVALID = 2;
  localparam int SB_REMPTY = 3;
  localparam int SB_FULL_R = 4;
  localparam int SB_FULL_F = 5;
  localparam int SB_WBUSY = 6;
  localparam int SB_RISE_LO = 7;
  localparam int SB_FALL_LO = 39;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_SETUP = 4'h1,
    S_FETCH = 4'h2,
    S_REQ = 4'h3,
    S_RD = 4'h4,
    S_RD_FIN = 4'h5,
    S_WR_FILL = 4'h6,
    S_WR_PUSH = 4'h7,
    S_WR_FIN = 4'h8,
    S_WR_SETTLE = 4'h9,
    S_NEXT = 4'hA,
    S_DONE = 4'hB,
    S_ABORT = 4'hC
  } pemi_state_t;
endpackage : pemi_pkg

// ===== pkg/pemi_cfg_if.sv
// Purpose: carries the register pair select and the two selected config words
// Assumes: one clock domain, the requester holds select steady
// Notes: words arrive one clock after the select
`timescale 1ns/1ps
interface pemi_cfg_if;
  logic [1:0] sel;
  logic [31:0] cfg_a;
  logic [31:0] cfg_b;
  modport requester (output sel, input cfg_a, input cfg_b);
  modport provider (input sel, output cfg_a, output cfg_b);
endinterface : pemi_cfg_if

// ===== hw/pemi_sync.sv
// Purpose: two flip-flop synchroniser for inputs from the memory side
// Assumes: multi-bit words are stable around the sampled link edge
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module pemi_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pemi_sync_t;
  pemi_sync_t r;
  pemi_sync_t next_r;
  always_comb begin
    next_r.meta = d;
    next_r.stable = r.meta;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign q = r.stable;
endmodule : pemi_sync

// ===== hw/pemi_cfg_mux.sv
// Purpose: presents one pair of config registers on two registered buses
// Assumes: config words are held by the register block
// Notes: one clock of latency from select to data
`timescale 1ns/1ps
module pemi_cfg_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pemi_pkg::NUM_CFG-1:0][31:0] cfg,
  pemi_cfg_if.provider bus
);
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
  } pemi_mux_t;
  pemi_mux_t r;
  pemi_mux_t next_r;
  always_comb begin
    next_r = r;
    case (bus.sel)
      pemi_pkg::PAIR_LOSS_MODE: begin
        next_r.a = cfg[pemi_pkg::SLOT_LOSS];
        next_r.b = cfg[pemi_pkg::SLOT_MODE];
      end
      pemi_pkg::PAIR_D1_D2: begin
        next_r.a = cfg[pemi_pkg::SLOT_D1];
        next_r.b = cfg[pemi_pkg::SLOT_D2];
      end
      pemi_pkg::PAIR_D3_D4: begin
        next_r.a = cfg[pemi_pkg::SLOT_D3];
        next_r.b = cfg[pemi_pkg::SLOT_D4];
      end
      default: begin
        next_r.a = cfg[pemi_pkg::SLOT_P];
        next_r.b = cfg[pemi_pkg::SLOT_Q];
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign bus.cfg_a = r.a;
  assign bus.cfg_b = r.b;
endmodule : pemi_cfg_mux

// ===== verification/pemi_monitor.sv
// Purpose: port-level checks of the memory port and register block
// Assumes: a single pclk domain, reset active low
// Notes: bound to pemi_top after the module
`timescale 1ns/1ps
module pemi_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [31:0] mem_req_address,
  input wire logic mem_access_request,
  input wire logic mem_read_not_write,
  input wire logic [1:0] mem_burst_length_code,
  input wire logic read_word_ack_rise,
  input wire logic write_word_ack_rise,
  input wire logic accel_start,
  input wire logic accel_done,
  input wire logic regenerate_request,
  input wire logic [1:0] register_pair_select,
  input wire logic [31:0] config_input_a,
  input wire logic [31:0] parity_p_pointer,
  input wire logic acc_rd_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_burst_code: assert property (mem_burst_length_code == pemi_pkg::BURST_CODE_32) else $error("bad burst code");
  a_word_acks_low: assert property (!read_word_ack_rise && !write_word_ack_rise) else $error("word ack active");
  a_req_held: assert property (mem_access_request && $past(mem_access_request)
    |-> $stable(mem_req_address) && $stable(mem_read_not_write)) else $error("request moved");
  a_start_pulse: assert property (accel_start |-> regenerate_request ##1 !accel_start) else $error("bad start");
  a_done_clears: assert property (accel_done |-> !regenerate_request ##1 !accel_done)
    else $error("request kept");
  a_apb_ready: assert property (psel && penable |-> pready) else $error("no ready");
  a_pair_words: assert property (register_pair_select == pemi_pkg::PAIR_P_Q
    |=> config_input_a == $past(parity_p_pointer)) else $error("wrong pair word");
  a_rd_pair: assert property ($rose(acc_rd_valid) |=> acc_rd_valid ##1 !acc_rd_valid) else $error("bad pair");
  c_start: cover property (accel_start);
  c_done: cover property (accel_done);
  c_ack: cover property ($fell(mem_access_request));
endmodule : pemi_monitor
bind pemi_top pemi_monitor pemi_monitor_inst (.*);

// ===== verification/pemi_mem_model.sv
// Purpose: behavioural memory controller port facing the block
// Assumes: one burst open at a time
// Notes: stalls two link edges in every four
`timescale 1ns/1ps
module pemi_mem_model (
  input logic mem_clk,
  input logic mem_access_request,
  input logic mem_read_not_write,
  input logic [31:0] mem_req_address,
  input logic read_burst_finished,
  input logic write_burst_finished,
  input logic read_path_clear,
  input logic write_path_clear,
  output logic mem_request_ack = 0,
  output logic [31:0] read_bus_rise = 0,
  output logic [31:0] read_bus_fall = 0,
  output logic read_word_valid = 0,
  output logic ctrl_read_queue_empty = 1,
  output logic ctrl_write_in_progress = 0,
  output logic ctrl_write_queue_full_rise = 0,
  output logic ctrl_write_queue_full_fall = 0
);
  logic act = 0;
  logic rd = 0;
  logic [31:0] base = 0;
  logic [31:0] n = 0;
  // outputs move on the falling link edge so they sit still where the block samples
  always @(negedge mem_clk) begin
    mem_request_ack <= mem_access_request && !act && !mem_request_ack;
    // a clear outranks a late acknowledge, so an abandoned burst never opens
    if (read_burst_finished || write_burst_finished || read_path_clear || write_path_clear) begin
      act <= 0;
    end else if (mem_request_ack) begin
      act <= 1;
      rd <= mem_read_not_write;
      base <= mem_req_address;
      n <= 0;
    end else if (act) begin
      n <= n + 1;
    end
    read_word_valid <= act && rd && n[1:0] != 2'h3;
    ctrl_read_queue_empty <= !(act && rd) || n[1:0] == 2'h2;
    read_bus_rise <= (act && rd && n[1:0] < 2'h2) ? base + n : ~read_bus_rise;
    read_bus_fall <= (act && rd && n[1:0] < 2'h2) ? ~(base + n) : ~read_bus_fall;
    ctrl_write_queue_full_rise <= act && !rd && n[1:0] == 2'h1;
    ctrl_write_queue_full_fall <= act && !rd && n[1:0] == 2'h3;
    ctrl_write_in_progress <= act && !rd;
  end
endmodule : pemi_mem_model

// ===== verification/pemi_top_tb_top.sv
// Purpose: self-checking bench for pemi_top
// Assumes: pclk 50 ns, link clock 400 ns
// Notes: one task per scenario
`timescale 1ns/1ps
module pemi_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mem_clk = 0, pready, pslverr, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, mem_req_address, read_bus_rise, read_bus_fall, r, first_rd, first_wr;
  logic [31:0] acc_rd_data, acc_wr_data = 0, data_block_pointer_1, parity_q_pointer;
  logic [4:0] read_word_index_rise = 0;
  logic acc_wr_valid = 1, acc_wr_ready, acc_rd_valid, accel_done, regenerate_request, rq = 0, seen = 0, wseen = 0;
  logic mem_access_request, mem_read_not_write, mem_request_ack, read_word_valid, ctrl_read_queue_empty;
  logic read_burst_finished, write_burst_finished, read_path_clear, write_path_clear;
  logic ctrl_write_in_progress, ctrl_write_queue_full_rise, ctrl_write_queue_full_fall;
  int mismatches = 0, n_compared = 0, n_req = 0;
  pemi_top pemi_top_inst (.*, .mem_burst_length_code(), .read_word_ack_rise(), .write_word_ack_rise(),
    .write_bus_rise(), .write_bus_fall(), .accel_start(), .register_pair_select(), .config_input_a(),
    .config_input_b(), .loss_code(), .data_block_pointer_2(), .data_block_pointer_3(), .mode_word(),
    .data_block_pointer_4(), .parity_p_pointer(), .status_indicator());
  pemi_mem_model pemi_mem_model_inst (.*);
  always #25 pclk = ~pclk;
  initial begin
    #13;
    forever #200 mem_clk = ~mem_clk;
  end
  always @(posedge pclk) begin
    rq <= mem_access_request;
    if (mem_access_request === 1'b1 && rq !== 1'b1) n_req++;
    if (acc_rd_valid === 1'b1 && !seen) begin
      first_rd <= acc_rd_data;
      seen <= 1;
    end
    if (mem_access_request === 1'b1 && rq !== 1'b1 && mem_read_not_write === 1'b0 && !wseen) begin
      first_wr <= mem_req_address;
      wseen <= 1;
    end
    if (acc_wr_ready === 1'b1) acc_wr_data <= acc_wr_data + 32'h1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic t_regs;
    for (int i = 0; i < 6; i++) apb(1, 12'h608 + 12'(4 * i), 32'(i + 1) << 16);
    apb(0, 12'h608, 0);
    chk(r, 32'h0001_0000);
    chk(data_block_pointer_1, 32'h0001_0000);
    chk(parity_q_pointer, 32'h0006_0000);
    apb(0, 12'h624, 0);
    chk(r, 32'h0);
    apb(0, 12'h700, 0);
    chk({31'h0, e}, 32'h1);
  endtask : t_regs
  task automatic t_op(input logic [2:0] m, input int w);
    int i;
    apb(1, 12'h620, {m, 29'h0});
    apb(1, 12'h604, 32'h3);
    n_req = 0;
    seen <= 0;
    wseen <= 0;
    apb(1, 12'h600, 32'h1);
    for (i = 0; i < 20000 && accel_done !== 1'b1; i++) @(negedge pclk);
    chk({31'h0, accel_done}, 32'h1);
    repeat (2) @(posedge pclk);
    chk(n_req, 12 + 4 * w);
    chk(first_rd, 32'h0001_0000);
    chk(first_wr, (m == 3'h2) ? 32'h0006_0000 : 32'h0005_0000);
    apb(0, 12'h600, 0);
    chk(r, 32'h0);
  endtask : t_op
  task automatic t_abort;
    int i;
    apb(1, 12'h600, 32'h1);
    for (i = 0; i < 2000 && mem_access_request !== 1'b1; i++) @(posedge pclk);
    apb(1, 12'h630, 32'h3);
    for (i = 0; i < 50 && read_path_clear !== 1'b1; i++) @(negedge pclk);
    chk({30'h0, read_path_clear, write_path_clear}, 32'h3);
    repeat (20) @(posedge pclk);
    apb(0, 12'h600, 0);
    chk(r, 32'h0);
  endtask : t_abort
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    logic [2:0] md [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    int wc [7] = '{1, 1, 1, 3, 2, 2, 2};
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    t_abort;
    for (int k = 0; k < 7; k++) t_op(md[k], wc[k]);
    tally_and_finish;
  end
  // seven operations of up to some 8000 cycles each, with margin
  initial begin
    #4000000;
    mismatches++;
    tally_and_finish;
  end
endmodule : pemi_top_tb_top
